// File: src/dce_map.vh
/*
  register offsets, field positions, codes and cycle counts of the
  channel transfer engine. assumes inclusion by its bare name.
*/
`ifndef DCE_MAP_VH
`define DCE_MAP_VH

// apb byte offsets
`define DCE_OFS_CTRL      8'h00
`define DCE_OFS_SRC       8'h04
`define DCE_OFS_DST       8'h08
`define DCE_OFS_SIZE      8'h0C
`define DCE_OFS_STAT      8'h10

// control register fields
`define DCE_F_MODE_HI     2
`define DCE_F_MODE_LO     0
`define DCE_F_SSTEP_HI    4
`define DCE_F_SSTEP_LO    3
`define DCE_F_DSTEP_HI    6
`define DCE_F_DSTEP_LO    5
`define DCE_F_SBYTE       7
`define DCE_F_DBYTE       8
`define DCE_F_LEVEL       9
`define DCE_F_ENABLE      10
`define DCE_F_DONE        11
`define DCE_F_ABORT       12
`define DCE_F_NMIEN       13
`define DCE_F_SWREQ       14

// transfer mode bits
`define DCE_MODE_REPEAT   2
`define DCE_MODE_BURST    1
`define DCE_MODE_BLOCK    0

// address step codes
`define DCE_STEP_DEC      2'h2
`define DCE_STEP_INC      2'h3

// reset values
`define DCE_RST_MODE      3'h0
`define DCE_RST_STEP      2'h0

// burst pacing
`define DCE_BURST_XFERS   3'h4
`define DCE_RELEASE_CYC   2'h2

`endif

// File: src/dce_sync3.v
/*
  three-stage synchroniser for pins, with agreement filter and rising
  edge pulse. assumes inputs asynchronous to mclk.
*/
module dce_sync3 #(
  parameter W = 2
) (
  input  wire         mclk,
  input  wire         reset,
  input  wire [W-1:0] pin_in,
  output reg  [W-1:0] level_ff,
  output reg  [W-1:0] rise_ff
);

  reg  [W-1:0] s1_ff;
  reg  [W-1:0] s2_ff;
  reg  [W-1:0] s3_ff;
  wire [W-1:0] nxt_level;

  // change counts once stage two and three agree
  assign nxt_level = (~(s2_ff ^ s3_ff) & s3_ff) | ((s2_ff ^ s3_ff) & level_ff);

  always @(posedge mclk) begin
    if (reset) begin
      s1_ff    <= {W{1'b0}};
      s2_ff    <= {W{1'b0}};
      s3_ff    <= {W{1'b0}};
      level_ff <= {W{1'b0}};
      rise_ff  <= {W{1'b0}};
    end else begin
      s1_ff    <= pin_in;
      s2_ff    <= s1_ff;
      s3_ff    <= s2_ff;
      level_ff <= nxt_level;
      rise_ff  <= nxt_level & ~level_ff;
    end
  end

endmodule

// File: src/dce_engine.v
/*
  one dma channel: apb register file, addressing and transfer-mode
  engine, two-cycle read/write on the shared memory bus, cpu hold.
  assumes mem_rdata valid in the same cycle as mem_rd, trigger and
  nmi asynchronous pins, apb3 master on mclk.
*/
// Function
// R1 - source and destination each step up, down or stay after every transfer
// R2 - addressing and transfer modes combine freely, held per channel
// R3 - word source to byte destination writes only the low byte
// R4 - byte source to word destination clears the upper byte
// R5 - codes 0..3 single, block, burst; enable self-clears at completion
// R6 - codes 4..7 repeated variants; enable stays set after completion
// R7 - single modes move one byte or word per trigger
// R8 - zero count at enable performs no transfers
// R9 - enabling copies addresses and count; step temps, decrement visible count
// R10 - count reaching zero reloads from temp copy and sets done flag
// R11 - single mode clears enable at zero; software must re-enable
// R12 - block moves whole block per trigger; triggers during block ignored
// R13 - each transfer holds cpu two cycles; block holds 2 x count
// R14 - repeated block stays enabled; next trigger starts a new block
// R15 - burst releases cpu two cycles after every four transfers; count restarts each block, so repeated burst of count 1..4 never releases
// R16 - burst clears enable at end; triggers during burst ignored
// R17 - repeated burst restarts at once until disabled or nmi abort
// R18 - nmi with abort enabled stops channel, clears enable, sets abort
// R19 - level select 0 starts on rising edge; 1 runs while trigger high
// R20 - level trigger low freezes block; resumes unless registers rewritten
module dce_engine #(
  parameter AW = 16,
  parameter DW = 16,
  parameter CW = 16
) (
  input  wire          mclk,
  input  wire          reset,
  input  wire          psel,
  input  wire          penable,
  input  wire          pwrite,
  input  wire [7:0]    paddr,
  input  wire [31:0]   pwdata,
  output reg  [31:0]   prdata_ff,
  output reg           pready_ff,
  output reg           pslverr_ff,
  input  wire          trigger_pin,
  input  wire          nmi_pin,
  output reg  [AW-1:0] mem_addr_ff,
  output reg           mem_rd_ff,
  output reg           mem_wr_ff,
  output reg           mem_byte_ff,
  output reg  [DW-1:0] mem_wdata_ff,
  input  wire [DW-1:0] mem_rdata,
  output reg           cpu_halt_ff
);

`include "dce_map.vh"

  localparam S_IDLE = 6'h01;
  localparam S_WAIT = 6'h02;
  localparam S_RD   = 6'h04;
  localparam S_WR   = 6'h08;
  localparam S_REL  = 6'h10;
  localparam S_HOLD = 6'h20;

  reg  [5:0]    state_ff;
  reg  [2:0]    mode_ff;
  reg  [1:0]    sstep_ff;
  reg  [1:0]    dstep_ff;
  reg           sbyte_ff;
  reg           dbyte_ff;
  reg           level_ff;
  reg           enable_ff;
  reg           done_ff;
  reg           abort_ff;
  reg           nmien_ff;
  reg           swreq_ff;
  reg  [AW-1:0] src_ff;
  reg  [AW-1:0] dst_ff;
  reg  [CW-1:0] size_ff;
  reg  [CW-1:0] tsize_ff;
  reg  [AW-1:0] tsrc_ff;
  reg  [AW-1:0] tdst_ff;
  reg  [2:0]    bcnt_ff;
  reg  [1:0]    rcnt_ff;

  reg  [5:0]    nxt_state;
  reg  [2:0]    nxt_mode;
  reg  [1:0]    nxt_sstep;
  reg  [1:0]    nxt_dstep;
  reg           nxt_sbyte;
  reg           nxt_dbyte;
  reg           nxt_level;
  reg           nxt_enable;
  reg           nxt_done;
  reg           nxt_abort;
  reg           nxt_nmien;
  reg           nxt_swreq;
  reg  [AW-1:0] nxt_src;
  reg  [AW-1:0] nxt_dst;
  reg  [CW-1:0] nxt_size;
  reg  [CW-1:0] nxt_tsize;
  reg  [AW-1:0] nxt_tsrc;
  reg  [AW-1:0] nxt_tdst;
  reg  [2:0]    nxt_bcnt;
  reg  [1:0]    nxt_rcnt;
  reg  [AW-1:0] nxt_mem_addr;
  reg           nxt_mem_rd;
  reg           nxt_mem_wr;
  reg           nxt_mem_byte;
  reg  [DW-1:0] nxt_mem_wdata;
  reg           nxt_halt;
  reg  [31:0]   nxt_prdata;
  reg           nxt_pslverr;

  wire [1:0]    pin_level;
  wire [1:0]    pin_rise;
  wire          trig_high;
  wire          trig_rise;
  wire          nmi_rise;
  wire          wr_en;
  wire          cfg_wr;
  wire          addr_ok;
  wire          abort_hit;
  wire          go;
  wire          is_single;
  wire          is_burst;
  wire          is_repeat;
  wire [31:0]   ctrl_word;

  dce_sync3 #(
    .W        (2)
  ) u_sync (
    .mclk     (mclk),
    .reset    (reset),
    .pin_in   ({nmi_pin, trigger_pin}),
    .level_ff (pin_level),
    .rise_ff  (pin_rise)
  );

  assign trig_high = pin_level[0];
  assign trig_rise = pin_rise[0];
  assign nmi_rise  = pin_rise[1];

  // step an address by one byte or one word
  function [AW-1:0] step_addr;
    input [AW-1:0] a;
    input [1:0]    sel;
    input          bmode;
    reg   [AW-1:0] amt;
    begin
      amt = bmode ? {{(AW-1){1'b0}}, 1'b1} : {{(AW-2){1'b0}}, 2'b10};
      if (sel == `DCE_STEP_INC) begin
        step_addr = a + amt; // R1
      end else if (sel == `DCE_STEP_DEC) begin
        step_addr = a - amt; // R1
      end else begin
        step_addr = a;
      end
    end
  endfunction

  assign is_repeat = mode_ff[`DCE_MODE_REPEAT];
  assign is_burst  = mode_ff[`DCE_MODE_BURST];
  assign is_single = ~mode_ff[`DCE_MODE_BURST] & ~mode_ff[`DCE_MODE_BLOCK];
  assign abort_hit = nmien_ff & nmi_rise;
  assign go        = swreq_ff | (level_ff ? trig_high : trig_rise); // R19

  assign wr_en   = psel & penable & pready_ff & pwrite;
  assign cfg_wr  = wr_en & addr_ok & (paddr != `DCE_OFS_STAT);
  assign addr_ok = (paddr == `DCE_OFS_CTRL) | (paddr == `DCE_OFS_SRC) |
                   (paddr == `DCE_OFS_DST) | (paddr == `DCE_OFS_SIZE) |
                   (paddr == `DCE_OFS_STAT);

  assign ctrl_word = {17'h00000, swreq_ff, nmien_ff, abort_ff, done_ff, enable_ff,
                      level_ff, dbyte_ff, sbyte_ff, dstep_ff, sstep_ff, mode_ff};

  always @* begin
    nxt_state     = state_ff;
    nxt_mode      = mode_ff;
    nxt_sstep     = sstep_ff;
    nxt_dstep     = dstep_ff;
    nxt_sbyte     = sbyte_ff;
    nxt_dbyte     = dbyte_ff;
    nxt_level     = level_ff;
    nxt_enable    = enable_ff;
    nxt_done      = done_ff;
    nxt_abort     = abort_ff;
    nxt_nmien     = nmien_ff;
    nxt_swreq     = swreq_ff;
    nxt_src       = src_ff;
    nxt_dst       = dst_ff;
    nxt_size      = size_ff;
    nxt_tsize     = tsize_ff;
    nxt_tsrc      = tsrc_ff;
    nxt_tdst      = tdst_ff;
    nxt_bcnt      = bcnt_ff;
    nxt_rcnt      = rcnt_ff;
    nxt_mem_addr  = mem_addr_ff;
    nxt_mem_rd    = 1'b0;
    nxt_mem_wr    = 1'b0;
    nxt_mem_byte  = mem_byte_ff;
    nxt_mem_wdata = mem_wdata_ff;
    nxt_halt      = 1'b0;

    // software writes, hardware events below take precedence
    if (wr_en && paddr == `DCE_OFS_CTRL) begin
      nxt_mode   = pwdata[`DCE_F_MODE_HI:`DCE_F_MODE_LO]; // R2
      nxt_sstep  = pwdata[`DCE_F_SSTEP_HI:`DCE_F_SSTEP_LO];
      nxt_dstep  = pwdata[`DCE_F_DSTEP_HI:`DCE_F_DSTEP_LO];
      nxt_sbyte  = pwdata[`DCE_F_SBYTE];
      nxt_dbyte  = pwdata[`DCE_F_DBYTE];
      nxt_level  = pwdata[`DCE_F_LEVEL];
      nxt_enable = pwdata[`DCE_F_ENABLE];
      nxt_nmien  = pwdata[`DCE_F_NMIEN];
      nxt_swreq  = pwdata[`DCE_F_SWREQ];
      nxt_done   = done_ff & ~pwdata[`DCE_F_DONE];
      nxt_abort  = abort_ff & ~pwdata[`DCE_F_ABORT];
    end
    if (wr_en && paddr == `DCE_OFS_SRC) begin
      nxt_src = pwdata[AW-1:0];
    end
    if (wr_en && paddr == `DCE_OFS_DST) begin
      nxt_dst = pwdata[AW-1:0];
    end
    if (wr_en && paddr == `DCE_OFS_SIZE) begin
      nxt_size = pwdata[CW-1:0];
    end

    case (state_ff)
      S_IDLE: begin
        // zero count never leaves idle
        if (enable_ff && size_ff != {CW{1'b0}}) begin // R8
          nxt_tsize = size_ff; // R9
          nxt_tsrc  = src_ff; // R9
          nxt_tdst  = dst_ff; // R9
          nxt_bcnt  = 3'h0;
          nxt_state = S_WAIT;
        end
      end
      S_WAIT: begin
        if (go) begin
          nxt_state    = S_RD;
        end
      end
      S_HOLD: begin
        // frozen block resumes unless reprogrammed
        if (cfg_wr) begin // R20
          nxt_state = S_IDLE;
        end else if (trig_high) begin // R20
          nxt_state = S_RD;
        end
      end
      S_RD: begin
        // capture read data, drive destination write
        if (sbyte_ff || dbyte_ff) begin
          nxt_mem_wdata = {{(DW-8){1'b0}}, mem_rdata[7:0]}; // R3 R4
        end else begin
          nxt_mem_wdata = mem_rdata;
        end
        nxt_mem_wr   = 1'b1;
        nxt_mem_addr = tdst_ff;
        nxt_mem_byte = dbyte_ff;
        nxt_halt     = 1'b1; // R13
        nxt_state    = S_WR;
      end
      S_WR: begin
        nxt_size = size_ff - {{(CW-1){1'b0}}, 1'b1}; // R9
        nxt_tsrc = step_addr(tsrc_ff, sstep_ff, sbyte_ff); // R1 R9
        nxt_tdst = step_addr(tdst_ff, dstep_ff, dbyte_ff); // R1 R9
        nxt_bcnt = bcnt_ff + 3'h1;
        if (size_ff == {{(CW-1){1'b0}}, 1'b1}) begin
          nxt_size = tsize_ff; // R10
          nxt_done = 1'b1; // R10
          nxt_tsrc = src_ff;
          nxt_tdst = dst_ff;
          nxt_bcnt = 3'h0;
          if (!is_repeat) begin
            nxt_enable = 1'b0; // R5 R11 R16
            nxt_state  = S_IDLE;
          end else if (is_burst) begin
            nxt_state  = S_RD; // R17
          end else begin
            nxt_state  = S_WAIT; // R6 R14
          end
        end else if (is_single) begin
          nxt_state = S_WAIT; // R7
        end else if (level_ff && !trig_high) begin
          nxt_state = S_HOLD; // R20
        end else if (is_burst && nxt_bcnt == `DCE_BURST_XFERS) begin
          nxt_bcnt  = 3'h0;
          nxt_rcnt  = 2'h0;
          nxt_state = S_REL; // R15
        end else begin
          nxt_state = S_RD; // R12
        end
      end
      S_REL: begin
        // cpu runs while released
        nxt_rcnt = rcnt_ff + 2'h1;
        if (nxt_rcnt == `DCE_RELEASE_CYC) begin // R15
          nxt_state = (level_ff && !trig_high) ? S_HOLD : S_RD;
        end
      end
      default: begin
        nxt_state = S_IDLE;
      end
    endcase

    // abort taken in any busy state; a read in flight still finishes its write
    if (state_ff != S_IDLE && abort_hit) begin
      nxt_enable = 1'b0; // R18 R17
      nxt_abort  = 1'b1; // R18
    end
    if (state_ff != S_IDLE && state_ff != S_RD && (abort_hit || !enable_ff)) begin
      nxt_state = S_IDLE; // R18 R17
    end

    // launch of a source read
    if (nxt_state == S_RD && state_ff != S_RD) begin
      nxt_mem_rd   = 1'b1;
      nxt_mem_addr = tsrc_ff;
      nxt_mem_byte = sbyte_ff;
      nxt_halt     = 1'b1; // R13
      nxt_swreq    = 1'b0;
      if (state_ff == S_WR) begin
        nxt_mem_addr = (size_ff == {{(CW-1){1'b0}}, 1'b1}) ? src_ff : nxt_tsrc;
      end
    end
  end

  always @* begin
    nxt_pslverr = ~addr_ok;
    case (paddr)
      `DCE_OFS_CTRL: nxt_prdata = ctrl_word;
      `DCE_OFS_SRC:  nxt_prdata = {{(32-AW){1'b0}}, src_ff};
      `DCE_OFS_DST:  nxt_prdata = {{(32-AW){1'b0}}, dst_ff};
      `DCE_OFS_SIZE: nxt_prdata = {{(32-CW){1'b0}}, size_ff};
      `DCE_OFS_STAT: nxt_prdata = {25'h0000000, cpu_halt_ff, state_ff};
      default:       nxt_prdata = 32'h00000000;
    endcase
  end

  always @(posedge mclk) begin
    if (reset) begin
      state_ff     <= S_IDLE;
      mode_ff      <= `DCE_RST_MODE;
      sstep_ff     <= `DCE_RST_STEP;
      dstep_ff     <= `DCE_RST_STEP;
      sbyte_ff     <= 1'b0;
      dbyte_ff     <= 1'b0;
      level_ff     <= 1'b0;
      enable_ff    <= 1'b0;
      done_ff      <= 1'b0;
      abort_ff     <= 1'b0;
      nmien_ff     <= 1'b0;
      swreq_ff     <= 1'b0;
      src_ff       <= {AW{1'b0}};
      dst_ff       <= {AW{1'b0}};
      size_ff      <= {CW{1'b0}};
      tsize_ff     <= {CW{1'b0}};
      tsrc_ff      <= {AW{1'b0}};
      tdst_ff      <= {AW{1'b0}};
      bcnt_ff      <= 3'h0;
      rcnt_ff      <= 2'h0;
      mem_addr_ff  <= {AW{1'b0}};
      mem_rd_ff    <= 1'b0;
      mem_wr_ff    <= 1'b0;
      mem_byte_ff  <= 1'b0;
      mem_wdata_ff <= {DW{1'b0}};
      cpu_halt_ff  <= 1'b0;
      prdata_ff    <= 32'h00000000;
      pready_ff    <= 1'b0;
      pslverr_ff   <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      mode_ff      <= nxt_mode;
      sstep_ff     <= nxt_sstep;
      dstep_ff     <= nxt_dstep;
      sbyte_ff     <= nxt_sbyte;
      dbyte_ff     <= nxt_dbyte;
      level_ff     <= nxt_level;
      enable_ff    <= nxt_enable;
      done_ff      <= nxt_done;
      abort_ff     <= nxt_abort;
      nmien_ff     <= nxt_nmien;
      swreq_ff     <= nxt_swreq;
      src_ff       <= nxt_src;
      dst_ff       <= nxt_dst;
      size_ff      <= nxt_size;
      tsize_ff     <= nxt_tsize;
      tsrc_ff      <= nxt_tsrc;
      tdst_ff      <= nxt_tdst;
      bcnt_ff      <= nxt_bcnt;
      rcnt_ff      <= nxt_rcnt;
      mem_addr_ff  <= nxt_mem_addr;
      mem_rd_ff    <= nxt_mem_rd;
      mem_wr_ff    <= nxt_mem_wr;
      mem_byte_ff  <= nxt_mem_byte;
      mem_wdata_ff <= nxt_mem_wdata;
      cpu_halt_ff  <= nxt_halt;
      pready_ff    <= psel & ~penable & ~pready_ff;
      if (psel && !penable) begin
        prdata_ff  <= nxt_prdata;
        pslverr_ff <= nxt_pslverr;
      end else if (!psel) begin
        pslverr_ff <= 1'b0;
      end
    end
  end

endmodule

// File: bench/dce_engine_chk.sv
/*
  checker for the channel engine: transfer pairing, cpu hold, byte lanes,
  apb ready pulse. assumes binding onto dce_engine, one clock mclk.
*/
module dce_chk #(
  parameter DW = 16
) (
  input wire          mclk,
  input wire          reset,
  input wire          pready_ff,
  input wire [DW-1:0] mem_rdata,
  input wire          mem_rd_ff,
  input wire          mem_wr_ff,
  input wire          mem_byte_ff,
  input wire [DW-1:0] mem_wdata_ff,
  input wire          cpu_halt_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  rd_wr_pair_a: assert property (mem_rd_ff |=> mem_wr_ff && !mem_rd_ff)
    else $error("write does not follow read");
  wr_after_rd_a: assert property (mem_wr_ff |-> $past(mem_rd_ff))
    else $error("write without read");
  rd_halt_a: assert property (mem_rd_ff |-> cpu_halt_ff)
    else $error("cpu not held in read");
  wr_halt_a: assert property (mem_wr_ff |-> cpu_halt_ff)
    else $error("cpu not held in write");
  halt_busy_a: assert property (cpu_halt_ff |-> mem_rd_ff || mem_wr_ff)
    else $error("cpu held outside transfer");
  byte_high_a: assert property (mem_wr_ff && mem_byte_ff |-> mem_wdata_ff[DW-1:8] == 0)
    else $error("byte write upper lane not zero");
  byte_low_a: assert property (mem_wr_ff |-> mem_wdata_ff[7:0] == $past(mem_rdata[7:0]))
    else $error("low byte not from source");
  word_clear_a: assert property (
    mem_wr_ff && !mem_byte_ff && $past(mem_byte_ff) |-> mem_wdata_ff[DW-1:8] == 0)
    else $error("byte to word upper not cleared");
  word_copy_a: assert property (
    mem_wr_ff && !mem_byte_ff && !$past(mem_byte_ff) |-> mem_wdata_ff == $past(mem_rdata))
    else $error("word copy data differs");
  pready_pulse_a: assert property (pready_ff |=> !pready_ff)
    else $error("ready longer than one cycle");
endmodule

// File: bench/dce_mem.sv
/*
  system memory model: 64 words, combinational read, byte lanes.
  assumes one-cycle rd and wr strobes on mclk; idle data is not held.
*/
module dce_mem (
  input  wire        mclk,
  input  wire [15:0] addr,
  input  wire        rd,
  input  wire        wr,
  input  wire        bsel,
  input  wire [15:0] wdata,
  output wire [15:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [0:63];
  logic [15:0] last_q = 16'h0000;
  wire  [15:0] w = mem[addr[6:1]];
  wire  [7:0]  b = addr[0] ? w[15:8] : w[7:0];
  initial for (int i = 0; i < 64; i++) mem[i] = {i[7:0] ^ 8'hA5, i[7:0]};
  // byte reads carry junk above the lane; idle bus shows inverse of last
  assign rdata = !rd ? ~last_q : (bsel ? {~b, b} : w);
  always @(posedge mclk) begin
    if (rd) last_q <= rdata;
    if (wr && !bsel) mem[addr[6:1]] <= wdata;
    else if (wr && addr[0]) mem[addr[6:1]][15:8] <= wdata[7:0];
    else if (wr) mem[addr[6:1]][7:0] <= wdata[7:0];
  end
endmodule

// File: bench/dce_engine_tb.sv
/*
  testbench of the channel engine: apb master, trigger and nmi pins.
  assumes dce_mem as system memory and dce_chk bound onto the engine.
*/
module dce_engine_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk, reset, psel, penable, pwrite, trigger_pin, nmi_pin, re;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata_ff, rq;
  logic        pready_ff, pslverr_ff, mem_rd_ff, mem_wr_ff, mem_byte_ff, cpu_halt_ff;
  logic [15:0] mem_addr_ff, mem_wdata_ff, mem_rdata;
  int          bad_count, samples_checked, rd_cnt, wr_cnt, halt_cnt, cyc, t0, t1, mark;

  dce_engine i_dce_engine (.mclk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata_ff, .pready_ff, .pslverr_ff, .trigger_pin, .nmi_pin, .mem_addr_ff,
    .mem_rd_ff, .mem_wr_ff, .mem_byte_ff, .mem_wdata_ff, .mem_rdata, .cpu_halt_ff);
  dce_mem i_dce_mem (.mclk, .addr(mem_addr_ff), .rd(mem_rd_ff), .wr(mem_wr_ff),
    .bsel(mem_byte_ff), .wdata(mem_wdata_ff), .rdata(mem_rdata));

  initial begin
    mclk = 0;
    forever #5 mclk = ~mclk;
  end
  // transfer and hold bookkeeping
  always @(posedge mclk) begin
    cyc++;
    if (cpu_halt_ff === 1'b1) halt_cnt++;
    if (mem_rd_ff === 1'b1) begin
      rd_cnt++;
      if (rd_cnt == mark) t0 = cyc;
    end
    if (mem_wr_ff === 1'b1) begin
      wr_cnt++;
      t1 = cyc;
    end
  end

  function logic [15:0] pat(input int i);
    return {i[7:0] ^ 8'hA5, i[7:0]};
  endfunction
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s exp %h got %h", nm, exp, got);
    end
  endtask
  task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    do @(posedge mclk); while (pready_ff !== 1'b1);
    rq = prdata_ff;
    re = pslverr_ff;
    psel <= 0;
    penable <= 0;
  endtask
  task setup(input logic [31:0] s, input logic [31:0] d, input logic [31:0] n,
             input logic [31:0] ctl);
    apb(8'h04, 1, s);
    apb(8'h08, 1, d);
    apb(8'h0C, 1, n);
    apb(8'h00, 1, ctl);
  endtask
  task pulse(input bit nmi);
    @(posedge mclk);
    if (nmi) nmi_pin <= 1;
    else trigger_pin <= 1;
    repeat (6) @(posedge mclk);
    nmi_pin <= 0;
    trigger_pin <= 0;
    repeat (6) @(posedge mclk);
  endtask
  task wait_wr(input int n);
    while (wr_cnt < n) @(posedge mclk);
  endtask

  task t_regs;
    apb(8'h00, 0, 0); chk("ctrl_rst", rq, 0);
    apb(8'h04, 1, 32'h0000_1234);
    apb(8'h04, 0, 0); chk("src_rb", rq, 32'h0000_1234);
    apb(8'h14, 0, 0); chk("unm_err", re, 1);
    chk("unm_data", rq, 0);
  endtask
  task t_zero;
    int w;
    w = wr_cnt;
    setup(32'h0, 32'h40, 32'h0, 32'h0);
    for (int m = 0; m < 8; m++) begin
      apb(8'h00, 1, 32'h4400 | m);
      repeat (10) @(posedge mclk);
      chk("zero_cnt", wr_cnt, w);
    end
    apb(8'h00, 1, 0);
  endtask
  task t_single;
    int w;
    w = wr_cnt;
    setup(32'h10, 32'h40, 32'h2, 32'h578);
    pulse(0); chk("one_per_trig", wr_cnt, w + 1);
    apb(8'h0C, 0, 0); chk("size_left", rq, 1);
    pulse(0); apb(8'h0C, 0, 0); chk("size_reload", rq, 2);
    apb(8'h00, 0, 0); chk("en_done", rq[11:10], 2'b10);
    pulse(0); chk("no_more", wr_cnt, w + 2);
    chk("byte_dst", i_dce_mem.mem[32], 16'h0908);
  endtask
  task t_block;
    int w, h;
    logic [15:0] e [3] = '{16'h00A7, 16'h0002, 16'h00A4};
    w = wr_cnt;
    h = halt_cnt;
    mark = rd_cnt + 1;
    setup(32'h05, 32'h50, 32'h3, 32'h4F1);
    pulse(0); chk("blk_cnt", wr_cnt, w + 3);
    chk("blk_halt", halt_cnt - h, 6);
    chk("blk_span", t1 - t0, 5);
    pulse(0); chk("blk_once", wr_cnt, w + 3);
    for (int k = 0; k < 3; k++) chk("blk_data", i_dce_mem.mem[40 + k], e[k]);
  endtask
  task t_rblock;
    int w;
    w = wr_cnt;
    setup(32'h14, 32'h5C, 32'h2, 32'hC7D);
    pulse(0); chk("rblk_cnt", wr_cnt, w + 2);
    apb(8'h00, 0, 0); chk("rblk_en", rq[11:10], 2'b11);
    pulse(0); chk("rblk_again", wr_cnt, w + 4);
    apb(8'h00, 1, 0);
    for (int k = 0; k < 2; k++) chk("rblk_data", i_dce_mem.mem[46 + k], pat(10 + k));
  endtask
  task t_level;
    int w, h;
    w = wr_cnt;
    setup(32'h20, 32'h30, 32'h8, 32'hE79);
    pulse(0);
    h = halt_cnt;
    apb(8'h0C, 0, 0); chk("lvl_left", rq, 5);
    chk("lvl_frozen", wr_cnt, w + 3);
    chk("lvl_cpu_free", halt_cnt - h, 0);
    @(posedge mclk);
    trigger_pin <= 1;
    wait_wr(w + 8);
    trigger_pin <= 0;
    repeat (8) @(posedge mclk);
    chk("lvl_total", wr_cnt, w + 8);
    for (int k = 0; k < 8; k++) chk("lvl_data", i_dce_mem.mem[24 + k], pat(16 + k));
    apb(8'h00, 0, 0); chk("lvl_en", rq[11:10], 2'b10);
  endtask
  task t_burst;
    int w, h;
    w = wr_cnt;
    h = halt_cnt;
    mark = rd_cnt + 1;
    setup(32'h60, 32'h70, 32'h5, 32'h4C7A);
    wait_wr(w + 5);
    repeat (4) @(posedge mclk);
    chk("bst_halt", halt_cnt - h, 10);
    chk("bst_span", t1 - t0, 11);
    apb(8'h00, 0, 0); chk("bst_en", rq[11:10], 2'b10);
    for (int k = 0; k < 5; k++) chk("bst_data", i_dce_mem.mem[56 + k], pat(48 + k));
  endtask
  task t_nmi;
    int w;
    w = wr_cnt;
    setup(32'h00, 32'h7E, 32'h2, 32'h6C06);
    wait_wr(w + 6);
    pulse(1);
    apb(8'h00, 0, 0); chk("abort", rq[12:10], 3'b110);
    w = wr_cnt;
    repeat (20) @(posedge mclk);
    chk("stopped", wr_cnt, w);
  endtask

  task end_sim;
    if (bad_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    trigger_pin = 0; nmi_pin = 0; reset = 1;
    repeat (4) @(posedge mclk);
    reset <= 0;
    repeat (6) @(posedge mclk);
    t_regs;
    t_zero;
    t_single;
    t_block;
    t_rblock;
    t_level;
    t_burst;
    t_nmi;
    end_sim;
  end
  initial begin
    repeat (5000) @(posedge mclk);
    bad_count++;
    end_sim;
  end
endmodule

bind dce_engine dce_chk #(.DW(DW)) i_dce_chk (.mclk, .reset, .pready_ff, .mem_rdata,
  .mem_rd_ff, .mem_wr_ff, .mem_byte_ff, .mem_wdata_ff, .cpu_halt_ff);
